/* shared/csbu_defines.svh */
// Constants for the compare, skip and branch unit.
// Assumes inclusion by bare name from the top-level design file only.
`ifndef CSBU_DEFINES_SVH
`define CSBU_DEFINES_SVH

// Register byte offsets on the APB side
`define CSBU_CTRL_OFS 8'h00
`define CSBU_FLAGS_OFS 8'h04
`define CSBU_STATUS_OFS 8'h08

// Control register fields and reset value
`define CSBU_CTRL_EN_BIT 0
`define CSBU_CTRL_RST 1'b1

// Status flag bit positions
`define CSBU_FLAG_C 0
`define CSBU_FLAG_Z 1
`define CSBU_FLAG_N 2
`define CSBU_FLAG_V 3
`define CSBU_FLAG_S 4
`define CSBU_FLAG_H 5
`define CSBU_FLAG_T 6
`define CSBU_FLAG_I 7
`define CSBU_FLAGS_RST 8'h00

// Status register fields
`define CSBU_STAT_BUSY_BIT 0
`define CSBU_STAT_SKIP_BIT 1
`define CSBU_STAT_TAKEN_BIT 2

// Cycle counts per instruction outcome
`define CSBU_CYC_PLAIN 2'h1
`define CSBU_CYC_TAKEN 2'h2
`define CSBU_CYC_SKIP_ONE 2'h2
`define CSBU_CYC_SKIP_TWO 2'h3

// Program counter steps
`define CSBU_PC_STEP 16'h0001
`define CSBU_PC_SKIP_ONE 16'h0002
`define CSBU_PC_SKIP_TWO 16'h0003

`endif

/* shared/csbu_pkg.sv */
// Types shared by the compare, skip and branch unit.
// Assumes the defines header sits beside it on the include path.
package csbu_pkg;

  // Instruction classes handed over by the fetch stage
  typedef enum logic [4:0] {
    OP_NONE,
    OP_SKIP_IF_REGS_EQUAL,
    OP_COMPARE_REGS,
    OP_COMPARE_REGS_WITH_CARRY,
    OP_COMPARE_REG_IMMEDIATE,
    OP_SKIP_IF_REG_BIT_CLEAR,
    OP_SKIP_IF_REG_BIT_SET,
    OP_SKIP_IF_IO_BIT_CLEAR,
    OP_SKIP_IF_IO_BIT_SET,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_EQUAL,
    OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_LOWER,
    OP_BRANCH_MINUS,
    OP_BRANCH_PLUS,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALF_CARRY_SET,
    OP_BRANCH_HALF_CARRY_CLEAR
  } csbu_op_e;

  // One instruction with its operands
  typedef struct packed {
    csbu_op_e op;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [7:0] io_val;
    logic [2:0] flag_sel;
    logic [6:0] disp;
    logic [15:0] pc;
    logic next_two_word;
  } csbu_req_s;

  // Outcome of one instruction
  typedef struct packed {
    logic done;
    logic [15:0] pc_next;
    logic skip;
    logic taken;
  } csbu_res_s;

  // Arithmetic flags of a compare
  typedef struct packed {
    logic h;
    logic v;
    logic n;
    logic z;
    logic c;
  } csbu_cmp_flags_s;

  typedef enum logic {ST_IDLE, ST_WAIT} csbu_state_e;

endpackage

/* hw/csbu_sub_flags.sv */
// Subtract-without-writeback flag generator.
// Assumes purely combinational use by the compare path.
`timescale 1ns/1ns
`default_nettype none
module csbu_sub_flags
  import csbu_pkg::*;
(
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic borrow_in,
  output var csbu_cmp_flags_s flags_out
);

  logic [7:0] diff;

  // Difference and borrow-based flags
  always_comb begin
    diff = minuend - subtrahend - {7'h00, borrow_in};
    flags_out.c = (~minuend[7] & subtrahend[7]) | (subtrahend[7] & diff[7]) |
                  (diff[7] & ~minuend[7]);
    flags_out.h = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3]) |
                  (diff[3] & ~minuend[3]);
    flags_out.v = (minuend[7] & ~subtrahend[7] & ~diff[7]) |
                  (~minuend[7] & subtrahend[7] & diff[7]);
    flags_out.n = diff[7];
    flags_out.z = (diff == 8'h00);
  end

endmodule
`default_nettype wire

/* hw/csbu_top.sv */
// Compare, conditional skip and conditional branch unit with APB registers.
// Assumes the fetch stage holds req stable while req_valid waits on ready.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "csbu_defines.svh"
module csbu_top
  import csbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic req_valid,
  input wire csbu_req_s req,
  output var logic req_ready,
  output var csbu_res_s res,
  output var logic [7:0] status_flags_register
);

  logic ctrl_en, next_ctrl_en;
  logic [7:0] next_flags;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  csbu_state_e state, next_state;
  logic [1:0] wait_cnt, next_wait_cnt;
  logic next_req_ready;
  csbu_res_s next_res;
  logic accept, apb_wr, apb_rd;
  logic is_skip, is_branch, is_cmp, cond_hit;
  logic [7:0] cmp_sub;
  logic cmp_cin;
  csbu_cmp_flags_s cmp_flags;
  logic [1:0] cycles;
  logic [15:0] disp_ext, pc_calc;
  logic n_xor_v;

  assign accept = req_valid & req_ready;
  assign disp_ext = {{9{req.disp[6]}}, req.disp};
  assign n_xor_v = status_flags_register[`CSBU_FLAG_N] ^
                   status_flags_register[`CSBU_FLAG_V];

  // Compare arithmetic
  csbu_sub_flags u_sub (
    .minuend(req.rd_val),
    .subtrahend(cmp_sub),
    .borrow_in(cmp_cin),
    .flags_out(cmp_flags)
  );

  // Instruction class decode and condition select
  always_comb begin
    is_skip = 1'b0;
    is_branch = 1'b0;
    is_cmp = 1'b0;
    cond_hit = 1'b0;
    cmp_sub = req.rr_val;
    cmp_cin = 1'b0;
    case (req.op)
      OP_SKIP_IF_REGS_EQUAL: begin
        is_skip = 1'b1;
        cond_hit = (req.rd_val == req.rr_val);
      end
      OP_COMPARE_REGS: begin
        is_cmp = 1'b1;
      end
      OP_COMPARE_REGS_WITH_CARRY: begin
        is_cmp = 1'b1;
        cmp_cin = status_flags_register[`CSBU_FLAG_C];
      end
      OP_COMPARE_REG_IMMEDIATE: begin
        is_cmp = 1'b1;
        cmp_sub = req.imm;
      end
      OP_SKIP_IF_REG_BIT_CLEAR: begin
        is_skip = 1'b1;
        cond_hit = ~req.rr_val[req.bit_sel];
      end
      OP_SKIP_IF_REG_BIT_SET: begin
        is_skip = 1'b1;
        cond_hit = req.rr_val[req.bit_sel];
      end
      OP_SKIP_IF_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        cond_hit = ~req.io_val[req.bit_sel];
      end
      OP_SKIP_IF_IO_BIT_SET: begin
        is_skip = 1'b1;
        cond_hit = req.io_val[req.bit_sel];
      end
      OP_BRANCH_FLAG_SET: begin
        is_branch = 1'b1;
        cond_hit = status_flags_register[req.flag_sel];
      end
      OP_BRANCH_FLAG_CLEAR: begin
        is_branch = 1'b1;
        cond_hit = ~status_flags_register[req.flag_sel];
      end
      OP_BRANCH_EQUAL: begin
        is_branch = 1'b1;
        cond_hit = status_flags_register[`CSBU_FLAG_Z];
      end
      OP_BRANCH_NOT_EQUAL: begin
        is_branch = 1'b1;
        cond_hit = ~status_flags_register[`CSBU_FLAG_Z];
      end
      OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: begin
        is_branch = 1'b1;
        cond_hit = status_flags_register[`CSBU_FLAG_C];
      end
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: begin
        is_branch = 1'b1;
        cond_hit = ~status_flags_register[`CSBU_FLAG_C];
      end
      OP_BRANCH_MINUS: begin
        is_branch = 1'b1;
        cond_hit = status_flags_register[`CSBU_FLAG_N];
      end
      OP_BRANCH_PLUS: begin
        is_branch = 1'b1;
        cond_hit = ~status_flags_register[`CSBU_FLAG_N];
      end
      OP_BRANCH_SIGNED_GE: begin
        is_branch = 1'b1;
        cond_hit = ~n_xor_v;
      end
      OP_BRANCH_SIGNED_LT: begin
        is_branch = 1'b1;
        cond_hit = n_xor_v;
      end
      OP_BRANCH_HALF_CARRY_SET: begin
        is_branch = 1'b1;
        cond_hit = status_flags_register[`CSBU_FLAG_H];
      end
      OP_BRANCH_HALF_CARRY_CLEAR: begin
        is_branch = 1'b1;
        cond_hit = ~status_flags_register[`CSBU_FLAG_H];
      end
      default: begin
        is_skip = 1'b0;
      end
    endcase
  end

  // Cycle cost and program counter outcome
  // signed word displacement
  always_comb begin
    if (is_skip && cond_hit) begin
      cycles = req.next_two_word ? `CSBU_CYC_SKIP_TWO : `CSBU_CYC_SKIP_ONE;
      pc_calc = req.pc + (req.next_two_word ? `CSBU_PC_SKIP_TWO :
                                              `CSBU_PC_SKIP_ONE);
    end else if (is_branch && cond_hit) begin
      cycles = `CSBU_CYC_TAKEN;
      pc_calc = req.pc + disp_ext + `CSBU_PC_STEP;
    end else begin
      cycles = `CSBU_CYC_PLAIN;
      pc_calc = req.pc + `CSBU_PC_STEP;
    end
  end

  // Sequencer: hold the result for the instruction's cycle count
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_req_ready = req_ready;
    next_res = res;
    next_res.done = 1'b0;
    case (state)
      ST_IDLE: begin
        next_req_ready = ctrl_en;
        if (accept) begin
          next_res.pc_next = pc_calc;
          next_res.skip = is_skip & cond_hit;
          next_res.taken = is_branch & cond_hit;
          if (cycles == `CSBU_CYC_PLAIN) begin
            next_res.done = 1'b1;
          end else begin
            next_state = ST_WAIT;
            next_wait_cnt = cycles - 2'h2;
            next_req_ready = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        if (wait_cnt == 2'h0) begin
          next_res.done = 1'b1;
          next_req_ready = ctrl_en;
          next_state = ST_IDLE;
        end else begin
          next_wait_cnt = wait_cnt - 2'h1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      wait_cnt <= 2'h0;
      req_ready <= 1'b0;
      res <= '0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      req_ready <= next_req_ready;
      res <= next_res;
    end
  end

  // APB slave: one wait state, error on unmapped offsets
  assign apb_rd = psel & penable & ~pready;
  assign apb_wr = psel & penable & pready & pwrite;
  always_comb begin
    next_pready = apb_rd;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_ctrl_en = ctrl_en;
    next_flags = status_flags_register;
    if (apb_rd) begin
      case (paddr)
        `CSBU_CTRL_OFS: next_prdata[`CSBU_CTRL_EN_BIT] = ctrl_en;
        `CSBU_FLAGS_OFS: next_prdata[7:0] = status_flags_register;
        `CSBU_STATUS_OFS: begin
          next_prdata[`CSBU_STAT_BUSY_BIT] = (state != ST_IDLE);
          next_prdata[`CSBU_STAT_SKIP_BIT] = res.skip;
          next_prdata[`CSBU_STAT_TAKEN_BIT] = res.taken;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
    if (apb_wr && paddr == `CSBU_CTRL_OFS) begin
      next_ctrl_en = pwdata[`CSBU_CTRL_EN_BIT];
    end
    // compare result beats a software flag write
    if (accept && is_cmp) begin
      next_flags[`CSBU_FLAG_C] = cmp_flags.c;
      next_flags[`CSBU_FLAG_Z] = cmp_flags.z;
      next_flags[`CSBU_FLAG_N] = cmp_flags.n;
      next_flags[`CSBU_FLAG_V] = cmp_flags.v;
      next_flags[`CSBU_FLAG_H] = cmp_flags.h;
    end else if (apb_wr && paddr == `CSBU_FLAGS_OFS) begin
      next_flags = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_en <= `CSBU_CTRL_RST;
      status_flags_register <= `CSBU_FLAGS_RST;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      ctrl_en <= next_ctrl_en;
      status_flags_register <= next_flags;
    end
  end

  // Checks on timing and outcome
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  skip_equal_a: assert property (
    accept && req.op == OP_SKIP_IF_REGS_EQUAL &&
    req.rd_val == req.rr_val && !req.next_two_word |=>
    !res.done ##1 res.done && res.skip &&
    res.pc_next == $past(req.pc, 2) + 16'h0002)
    else $error("equal skip timing or target wrong");

  cmp_flags_a: assert property (
    accept && req.op == OP_COMPARE_REG_IMMEDIATE |=> res.done &&
    status_flags_register[`CSBU_FLAG_Z] ==
    ($past(req.rd_val) == $past(req.imm)))
    else $error("compare zero flag wrong");

  reg_bit_a: assert property (
    accept && req.op == OP_SKIP_IF_REG_BIT_SET &&
    !req.rr_val[req.bit_sel] |=> res.done && !res.skip &&
    $stable(status_flags_register))
    else $error("register bit skip wrong");

  io_bit_a: assert property (
    accept && req.op == OP_SKIP_IF_IO_BIT_CLEAR &&
    !req.io_val[req.bit_sel] && req.next_two_word |=>
    !res.done [*2] ##1 res.done && res.skip)
    else $error("io bit skip not three cycles");

  flag_branch_a: assert property (
    accept && req.op == OP_BRANCH_FLAG_SET &&
    status_flags_register[req.flag_sel] |=> !res.done ##1 res.taken)
    else $error("flag branch not taken in two");

  equal_branch_a: assert property (
    accept && req.op == OP_BRANCH_EQUAL &&
    !status_flags_register[`CSBU_FLAG_Z] |=> res.done && !res.taken)
    else $error("equal branch taken on clear zero");

  carry_branch_a: assert property (
    accept && req.op == OP_BRANCH_CARRY_CLEAR &&
    !status_flags_register[`CSBU_FLAG_C] |-> ##2 res.done && res.taken)
    else $error("carry clear branch not taken");

  lower_alias_a: assert property (
    accept && req.op == OP_BRANCH_LOWER &&
    !status_flags_register[`CSBU_FLAG_C] |=> res.done && !res.taken)
    else $error("lower branch differs from carry set");

  plus_branch_a: assert property (
    accept && req.op == OP_BRANCH_PLUS &&
    status_flags_register[`CSBU_FLAG_N] |=> res.done && !res.taken)
    else $error("plus branch taken on negative");

  signed_ge_a: assert property (
    accept && req.op == OP_BRANCH_SIGNED_GE && !n_xor_v |=>
    ##1 res.done && res.taken)
    else $error("signed ge branch not taken");

  signed_lt_a: assert property (
    accept && req.op == OP_BRANCH_SIGNED_LT && !n_xor_v |=>
    res.done && !res.taken)
    else $error("signed lt branch taken wrongly");

  half_carry_a: assert property (
    accept && req.op == OP_BRANCH_HALF_CARRY_CLEAR &&
    !status_flags_register[`CSBU_FLAG_H] |=> ##1 res.done && res.taken)
    else $error("half carry clear branch not taken");

  branch_target_a: assert property (
    accept && is_branch && cond_hit |=> ##1
    res.pc_next == $past(req.pc, 2) + 16'h0001 +
    {{9{$past(req.disp[6], 2)}}, $past(req.disp, 2)})
    else $error("branch target wrong");

endmodule
`default_nettype wire

/* tb/csbu_fetch_model.sv */
// Fetch-side model: offers queued instructions on the request port.
// Assumes the bench fills q and that req_ready behaves as a level handshake.
`timescale 1ns/1ns
`default_nettype none
module csbu_fetch_model
  import csbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_ready,
  output var logic req_valid,
  output var csbu_req_s req
);
  csbu_req_s q[$];
  int gap;
  logic next_valid;

  // Hold each offer until taken, then pause 0 to 2 cycles at random
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_valid <= 1'b0;
      req <= '0;
      gap = 0;
    end else begin
      next_valid = req_valid && !req_ready;
      if (req_valid && req_ready) gap = $urandom_range(0, 2);
      else if (gap > 0) gap--;
      if (!next_valid && gap == 0 && q.size() > 0) begin
        next_valid = 1'b1;
        req <= q.pop_front();
      end else if (!next_valid) begin
        req <= ~req; // Idle bus inverts the stale operands every cycle
      end
      req_valid <= next_valid;
    end
  end
endmodule
`default_nettype wire

/* tb/csbu_top_tb.sv */
// Self-checking bench for the compare, skip and branch unit.
// Assumes the fetch model file and the design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module csbu_top_tb
  import csbu_pkg::*;
;
  typedef struct {
    logic [15:0] pc; logic sk; logic tk; int lat; logic [7:0] fl;
  } csbu_note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, flags;
  logic [31:0] pwdata, prdata, rd;
  logic req_valid, req_ready, er;
  csbu_req_s req, r;
  csbu_res_s res;
  logic [7:0] mflags;
  csbu_note_s notes[$], n;
  int take_q[$];
  int n_fail, comparisons, cyc, tcnt, t;

  csbu_top u_csbu_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .res(res),
    .status_flags_register(flags));
  csbu_fetch_model u_csbu_fetch_model (.pclk(pclk), .presetn(presetn),
    .req_ready(req_ready), .req_valid(req_valid), .req(req));

  always #5 pclk = ~pclk;

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // APB transfer held until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e, logic ee);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, rd, e);
    check({nm, "_err"}, er, ee);
  endtask

  // Expected outcome and flags from the current flag model
  function automatic csbu_note_s predict(csbu_req_s q);
    csbu_note_s o;
    logic [8:0] d;
    logic [4:0] hd;
    logic [7:0] b, f;
    logic ci;
    f = mflags;
    b = (q.op == OP_COMPARE_REG_IMMEDIATE) ? q.imm : q.rr_val;
    ci = (q.op == OP_COMPARE_REGS_WITH_CARRY) ? f[0] : 1'b0;
    d = {1'b0, q.rd_val} - {1'b0, b} - ci;
    hd = {1'b0, q.rd_val[3:0]} - {1'b0, b[3:0]} - ci;
    o.sk = 0; o.tk = 0;
    case (q.op)
      OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_CARRY,
      OP_COMPARE_REG_IMMEDIATE: begin
        f[0] = d[8]; f[1] = (d[7:0] == 0); f[2] = d[7]; f[5] = hd[4];
        f[3] = (q.rd_val[7] & ~b[7] & ~d[7]) | (~q.rd_val[7] & b[7] & d[7]);
      end
      OP_SKIP_IF_REGS_EQUAL: o.sk = (q.rd_val == q.rr_val);
      OP_SKIP_IF_REG_BIT_CLEAR: o.sk = !q.rr_val[q.bit_sel];
      OP_SKIP_IF_REG_BIT_SET: o.sk = q.rr_val[q.bit_sel];
      OP_SKIP_IF_IO_BIT_CLEAR: o.sk = !q.io_val[q.bit_sel];
      OP_SKIP_IF_IO_BIT_SET: o.sk = q.io_val[q.bit_sel];
      OP_BRANCH_FLAG_SET: o.tk = f[q.flag_sel];
      OP_BRANCH_FLAG_CLEAR: o.tk = !f[q.flag_sel];
      OP_BRANCH_EQUAL: o.tk = f[1];
      OP_BRANCH_NOT_EQUAL: o.tk = !f[1];
      OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: o.tk = f[0];
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: o.tk = !f[0];
      OP_BRANCH_MINUS: o.tk = f[2];
      OP_BRANCH_PLUS: o.tk = !f[2];
      OP_BRANCH_SIGNED_GE: o.tk = !(f[2] ^ f[3]);
      OP_BRANCH_SIGNED_LT: o.tk = f[2] ^ f[3];
      OP_BRANCH_HALF_CARRY_SET: o.tk = f[5];
      OP_BRANCH_HALF_CARRY_CLEAR: o.tk = !f[5];
      default: o.sk = 0;
    endcase
    if (o.tk) o.pc = q.pc + {{9{q.disp[6]}}, q.disp} + 16'h0001;
    else if (o.sk) o.pc = q.pc + (q.next_two_word ? 16'h0003 : 16'h0002);
    else o.pc = q.pc + 16'h0001;
    o.lat = o.tk ? 2 : (o.sk ? (q.next_two_word ? 3 : 2) : 1);
    o.fl = f;
    mflags = f;
    return o;
  endfunction

  task automatic issue(csbu_req_s q);
    notes.push_back(predict(q));
    u_csbu_fetch_model.q.push_back(q);
  endtask

  task automatic set_flags(logic [7:0] v);
    while (notes.size() > 0 || req_valid !== 1'b0) @(posedge pclk);
    apb(1'b1, 8'h04, {24'h00_0000, v});
    mflags = v;
    rd_chk("flags_rb", 8'h04, {24'h00_0000, v}, 1'b0);
  endtask

  // Match each done pulse with the oldest note and its take edge
  always @(posedge pclk) begin
    if (presetn) begin
      cyc++;
      if (req_valid && req_ready) take_q.push_back(cyc);
      if (res.done === 1'b1) begin
        if (notes.size() == 0 || take_q.size() == 0) begin
          check("unexpected_done", 1'b1, 1'b0);
        end else begin
          n = notes.pop_front();
          t = take_q.pop_front();
          check("pc_next", res.pc_next, n.pc);
          check("skip", res.skip, n.sk);
          check("taken", res.taken, n.tk);
          check("flags", flags, n.fl);
          check("cycles", cyc - t, n.lat);
        end
      end
    end
  end

  // Cut a hang short
  always @(posedge pclk) begin
    tcnt++;
    if (tcnt == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0000_0000; mflags = 8'h00;
    n_fail = 0; comparisons = 0; cyc = 0; tcnt = 0;
    void'($urandom(42527));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl_rst", 8'h00, 32'h0000_0001, 1'b0);
    rd_chk("flags_rst", 8'h04, 32'h0000_0000, 1'b0);
    rd_chk("status_rst", 8'h08, 32'h0000_0000, 1'b0);
    rd_chk("unmapped", 8'h0C, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h08, 32'hFFFF_FFFF);
    rd_chk("status_ro", 8'h08, 32'h0000_0000, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    check("ready_off", req_ready, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_0001);
    // Two sweeps of every op, starting from all-clear then all-set flags, then random traffic
    for (int i = 0; i < 46 + 400; i++) begin
      if (i < 46 && i % 23 == 0) set_flags(i == 0 ? 8'h00 : 8'hFF);
      if (i >= 46 && i % 25 == 0) set_flags(8'($urandom()));
      r = csbu_req_s'({$urandom(), $urandom(), 3'($urandom())});
      r.op = (i < 46) ? csbu_op_e'(i % 23) : csbu_op_e'($urandom_range(0, 22));
      if ($urandom_range(0, 1)) r.rr_val = r.rd_val;
      if (r.op == OP_SKIP_IF_REG_BIT_CLEAR || r.op == OP_SKIP_IF_REG_BIT_SET)
        r.rd_val = r.rr_val;
      issue(r);
    end
    set_flags(8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
